// ### core/alu_mac_mode_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// RQ1 - Fractional product sign-extended, shifted left once
// RQ2 - Product bit 31 lands on accumulator bit 32
// RQ3 - Integer product added unshifted, 32.0 result
// RQ4 - Mode bit 4 selects fractional or integer
// RQ5 - 40-bit adder adds or subtracts the product
// RQ6 - Upper word holds sign extension of product bit 31 plus accumulation
// RQ7 - Mode bit 2 makes overflow flag sticky
// RQ8 - Non-sticky overflow clears on clean ALU operation
// RQ9 - Sticky overflow clears only by software write
// RQ10 - Mode bit 3 enables ALU result saturation
// RQ11 - No overflow: result written unmodified
// RQ12 - Overflow without carry saturates to maximum positive
// RQ13 - Overflow with carry saturates to maximum negative
// RQ14 - Feedback register wraps; flags unchanged by saturation
// RQ15 - Control bit 7 selects biased or unbiased rounding
// RQ16 - Rounding adds one at bit 15
// RQ17 - Unbiased midpoint forces result bit 16 to zero
// RQ18 - Biased midpoint always rounds upward
// RQ19 - Low word after rounding is invalid
// RQ20 - Rounding targets accumulator or shifter result set
// RQ21 - Overflow flag set on unpredicted sign change
// RQ22 - Mode bits in effect at execution apply
module alu_mac_mode_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [alu_mac_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [alu_mac_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import alu_mac_pkg::*;

  arith_if io ();
  alu_unit u_alu (.io(io.alu_side));
  mac_unit u_mac (.io(io.mac_side));

  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] waddr;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [ADDR_W-1:0] wofs;
  logic [ADDR_W-1:0] rofs;
  logic alu_exec;
  logic mac_exec;
  logic status_wr;
  logic alu_dest_fb;
  logic mac_to_shifter;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;

  logic overflow_sticky_select;
  logic alu_saturate_enable;
  logic multiplier_integer_mode;
  logic rounding_type_select;
  logic alu_overflow_flag;
  logic alu_carry_flag;
  logic [DATA_W-1:0] x_operand;
  logic [DATA_W-1:0] y_operand;
  logic [DATA_W-1:0] alu_result_register;
  logic [DATA_W-1:0] alu_feedback_register;
  logic [ACC_W-1:0] multiply_accumulator;
  logic [ACC_W-1:0] shifter_result_set;
  logic [DATA_W-1:0] next_alu_result;

  function automatic logic mapped(input logic [ADDR_W-1:0] ofs);
    mapped = (ofs <= SHF_UP_OFS);
  endfunction : mapped

  function automatic logic [31:0] upper_ext(input logic [ACC_W-1:0] acc);
    upper_ext = {{(32-UPPER_BITS){acc[ACC_W-1]}}, acc[ACC_W-1:ACC_W-UPPER_BITS]};
  endfunction : upper_ext

  // Write happens in the cycle both address and data are held
  assign do_write = aw_full && w_full && !bvalid;
  assign wofs = {waddr[ADDR_W-1:2], 2'b00};
  assign rofs = {araddr[ADDR_W-1:2], 2'b00};
  assign wr_ok = mapped(wofs);
  assign status_wr = do_write && (wofs == STATUS_OFS) && wstrb_q[0];
  assign alu_exec = do_write && (wofs == ALU_CMD_OFS) && wstrb_q[0];
  assign mac_exec = do_write && (wofs == MAC_CMD_OFS) && wstrb_q[0];
  assign alu_dest_fb = wdata_q[ALU_DEST_BIT];
  assign mac_to_shifter = wdata_q[MAC_TGT_BIT];

  // Operands and modes are the registered values at execution time
  assign io.x = x_operand;
  assign io.y = y_operand;
  assign io.alu_op = alu_op_t'(wdata_q[2:0]);
  assign io.carry_in = alu_carry_flag;
  assign io.mac_op = mac_op_t'(wdata_q[1:0]);
  assign io.x_signed = wdata_q[MAC_XS_BIT];
  assign io.y_signed = wdata_q[MAC_YS_BIT];
  assign io.int_mode = multiplier_integer_mode; // RQ4 RQ22
  assign io.round = wdata_q[MAC_RND_BIT];
  assign io.biased = rounding_type_select; // RQ15
  assign io.acc_in = mac_to_shifter ? shifter_result_set : multiply_accumulator; // RQ20

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_full <= 1'b0;
      waddr <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_full <= 1'b1;
      waddr <= awaddr;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_full <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_full <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (do_write) begin
      w_full <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Mode and rounding controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_sticky_select <= 1'b0;
      alu_saturate_enable <= 1'b0;
      multiplier_integer_mode <= 1'b0;
      rounding_type_select <= 1'b0;
    end else if (do_write && wstrb_q[0]) begin
      if (wofs == MODE_OFS) begin
        overflow_sticky_select <= wdata_q[STICKY_BIT]; // RQ7
        alu_saturate_enable <= wdata_q[SAT_BIT]; // RQ10
        multiplier_integer_mode <= wdata_q[INT_MODE_BIT]; // RQ4
      end
      if (wofs == INTCTL_OFS) begin
        rounding_type_select <= wdata_q[BIAS_BIT]; // RQ15
      end
    end
  end

  // Operand register, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      x_operand <= '0;
      y_operand <= '0;
    end else if (do_write && (wofs == OPERAND_OFS)) begin
      if (wstrb_q[0]) x_operand[7:0] <= wdata_q[7:0];
      if (wstrb_q[1]) x_operand[15:8] <= wdata_q[15:8];
      if (wstrb_q[2]) y_operand[7:0] <= wdata_q[23:16];
      if (wstrb_q[3]) y_operand[15:8] <= wdata_q[31:24];
    end
  end

  // Overflow flag; an overflowing operation beats a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alu_overflow_flag <= 1'b0;
    end else if (alu_exec && io.alu_ovf) begin
      alu_overflow_flag <= 1'b1; // RQ21
    end else if (status_wr) begin
      alu_overflow_flag <= wdata_q[OVF_BIT]; // RQ8 RQ9
    end else if (alu_exec && !overflow_sticky_select) begin
      alu_overflow_flag <= 1'b0; // RQ8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alu_carry_flag <= 1'b0;
    end else if (alu_exec) begin
      alu_carry_flag <= io.alu_carry;
    end else if (status_wr) begin
      alu_carry_flag <= wdata_q[CARRY_BIT];
    end
  end

  // Saturation depends on this operation's own overflow and carry
  always_comb begin
    next_alu_result = io.alu_res; // RQ11
    if (alu_saturate_enable && io.alu_ovf) begin
      next_alu_result = io.alu_carry ? MAX_NEG : MAX_POS; // RQ12 RQ13
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alu_result_register <= '0;
      alu_feedback_register <= '0;
    end else if (alu_exec) begin
      if (alu_dest_fb) begin
        alu_feedback_register <= io.alu_res; // RQ14
      end else begin
        alu_result_register <= next_alu_result; // RQ10
      end
    end
  end

  // Whole 40-bit result lands in the chosen set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      multiply_accumulator <= '0;
      shifter_result_set <= '0;
    end else if (mac_exec) begin
      if (mac_to_shifter) begin
        shifter_result_set <= io.acc_out; // RQ20
      end else begin
        multiply_accumulator <= io.acc_out; // RQ5 RQ6
      end
    end
  end

  // Read decode; upper word shows 8 bits sign-extended
  always_comb begin
    rd_ok = 1'b1;
    rd_word = '0;
    case (rofs)
      MODE_OFS: begin
        rd_word[STICKY_BIT] = overflow_sticky_select;
        rd_word[SAT_BIT] = alu_saturate_enable;
        rd_word[INT_MODE_BIT] = multiplier_integer_mode;
      end
      INTCTL_OFS: rd_word[BIAS_BIT] = rounding_type_select;
      STATUS_OFS: begin
        rd_word[OVF_BIT] = alu_overflow_flag;
        rd_word[CARRY_BIT] = alu_carry_flag;
      end
      OPERAND_OFS: rd_word = {y_operand, x_operand};
      ALU_CMD_OFS: rd_word = '0;
      MAC_CMD_OFS: rd_word = '0;
      ALU_RES_OFS: rd_word[DATA_W-1:0] = alu_result_register;
      ALU_FB_OFS: rd_word[DATA_W-1:0] = alu_feedback_register;
      ACC_LO_OFS: rd_word[DATA_W-1:0] = multiply_accumulator[DATA_W-1:0];
      ACC_MID_OFS: rd_word[DATA_W-1:0] = multiply_accumulator[2*DATA_W-1:DATA_W];
      ACC_UP_OFS: rd_word = upper_ext(multiply_accumulator);
      SHF_LO_OFS: rd_word[DATA_W-1:0] = shifter_result_set[DATA_W-1:0];
      SHF_MID_OFS: rd_word[DATA_W-1:0] = shifter_result_set[2*DATA_W-1:DATA_W];
      SHF_UP_OFS: rd_word = upper_ext(shifter_result_set);
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_frac_mul;
    mac_exec && !multiplier_integer_mode && io.mac_op == MAC_MUL && !io.round && !mac_to_shifter
      && io.x_signed && io.y_signed;
  endsequence

  sequence s_int_mul;
    mac_exec && multiplier_integer_mode && io.mac_op == MAC_MUL && !io.round && !mac_to_shifter
      && io.x_signed && io.y_signed;
  endsequence

  sequence s_alu_to_result;
    alu_exec && !alu_dest_fb && alu_saturate_enable;
  endsequence

  sequence s_round_tie;
    mac_exec && io.round && io.round_tie && !mac_to_shifter;
  endsequence

  a_frac_product_align: assert property ( // RQ1
    s_frac_mul |=> multiply_accumulator[0] == 1'b0
      && $signed(multiply_accumulator) == ($signed($past(x_operand)) * $signed($past(y_operand))) * 2)
    else $error("fractional product misaligned");

  a_int_product_plain: assert property ( // RQ3
    s_int_mul |=> $signed(multiply_accumulator) == $signed($past(x_operand)) * $signed($past(y_operand)))
    else $error("integer product shifted");

  a_sat_max_pos: assert property ( // RQ12
    s_alu_to_result ##0 (io.alu_ovf && !io.alu_carry) |=> alu_result_register == MAX_POS)
    else $error("no positive saturation");

  a_sat_max_neg: assert property ( // RQ13
    s_alu_to_result ##0 (io.alu_ovf && io.alu_carry) |=> alu_result_register == MAX_NEG)
    else $error("no negative saturation");

  a_sat_passthrough: assert property ( // RQ11
    s_alu_to_result ##0 !io.alu_ovf |=> alu_result_register == $past(io.alu_res))
    else $error("unsaturated result altered");

  a_feedback_wraps: assert property ( // RQ14
    alu_exec && alu_dest_fb |=> alu_feedback_register == $past(io.alu_res)
      && alu_overflow_flag == ($past(io.alu_ovf) || ($past(alu_overflow_flag) && $past(overflow_sticky_select))))
    else $error("feedback result not wrapped");

  a_sticky_overflow_hold: assert property ( // RQ9
    alu_overflow_flag && overflow_sticky_select && alu_exec ##0 !io.alu_ovf |=> alu_overflow_flag)
    else $error("sticky overflow lost");

  a_plain_overflow_clear: assert property ( // RQ8
    alu_overflow_flag && !overflow_sticky_select && alu_exec ##0 !io.alu_ovf |=> !alu_overflow_flag)
    else $error("non-sticky overflow held");

  a_unbiased_tie_even: assert property ( // RQ17
    s_round_tie ##0 !rounding_type_select |=> multiply_accumulator[RND_FORCE_BIT] == 1'b0)
    else $error("unbiased tie not forced even");

  a_biased_tie_up: assert property ( // RQ18
    s_round_tie ##0 rounding_type_select |=> multiply_accumulator[RND_FORCE_BIT] != $past(io.pre_bit16)
      && multiply_accumulator[DATA_W-1:0] == '0)
    else $error("biased tie not rounded up");

  a_write_answer: assert property (
    do_write |=> bvalid ##0 (!awready && !wready))
    else $error("write response missing");

  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready && rdata == $past(rd_word))
    else $error("read response malformed");

  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped");
endmodule : alu_mac_mode_control

// ### core/alu_mac_pkg.sv
package alu_mac_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int ACC_W = 40;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] MODE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] INTCTL_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] OPERAND_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] ALU_CMD_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] ALU_RES_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] ALU_FB_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] MAC_CMD_OFS = 8'h1c;
  localparam logic [ADDR_W-1:0] ACC_LO_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] ACC_MID_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] ACC_UP_OFS = 8'h28;
  localparam logic [ADDR_W-1:0] SHF_LO_OFS = 8'h2c;
  localparam logic [ADDR_W-1:0] SHF_MID_OFS = 8'h30;
  localparam logic [ADDR_W-1:0] SHF_UP_OFS = 8'h34;

  // Field positions
  localparam int STICKY_BIT = 2;
  localparam int SAT_BIT = 3;
  localparam int INT_MODE_BIT = 4;
  localparam int BIAS_BIT = 7;
  localparam int OVF_BIT = 0;
  localparam int CARRY_BIT = 1;
  localparam int ALU_DEST_BIT = 3;
  localparam int MAC_XS_BIT = 2;
  localparam int MAC_YS_BIT = 3;
  localparam int MAC_RND_BIT = 4;
  localparam int MAC_TGT_BIT = 5;
  localparam int UPPER_BITS = 8;

  localparam logic [DATA_W-1:0] MAX_POS = 16'h7fff;
  localparam logic [DATA_W-1:0] MAX_NEG = 16'h8000;
  localparam logic [DATA_W-1:0] RND_HALF = 16'h8000;
  localparam logic [ACC_W-1:0] RND_ONE = 40'h0000008000;
  localparam int RND_FORCE_BIT = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_SUB = 3'h1,
    ALU_ADDC = 3'h2,
    ALU_AND = 3'h3,
    ALU_PASS = 3'h4
  } alu_op_t;

  typedef enum logic [1:0] {
    MAC_MUL = 2'h0,
    MAC_ADD = 2'h1,
    MAC_SUB = 2'h2
  } mac_op_t;
endpackage : alu_mac_pkg

// ### core/alu_unit.sv
`timescale 1ns/1ps
module alu_unit (
  arith_if.alu_side io
);
  import alu_mac_pkg::*;
  logic [DATA_W:0] sum;
  logic [DATA_W-1:0] yv;
  logic cin;

  always_comb begin
    yv = io.y;
    cin = 1'b0;
    case (io.alu_op)
      ALU_SUB: begin
        yv = ~io.y;
        cin = 1'b1;
      end
      ALU_ADDC: cin = io.carry_in;
      default: ;
    endcase
    sum = {1'b0, io.x} + {1'b0, yv} + {{DATA_W{1'b0}}, cin};
    io.alu_res = sum[DATA_W-1:0];
    io.alu_carry = sum[DATA_W];
    // Sign change that the operand signs do not predict
    io.alu_ovf = (io.x[DATA_W-1] == yv[DATA_W-1]) && (sum[DATA_W-1] != io.x[DATA_W-1]); // RQ21
    case (io.alu_op)
      ALU_AND: begin
        io.alu_res = io.x & io.y;
        io.alu_ovf = 1'b0;
        io.alu_carry = 1'b0;
      end
      ALU_PASS: begin
        io.alu_res = io.x;
        io.alu_ovf = 1'b0;
        io.alu_carry = 1'b0;
      end
      default: ;
    endcase
  end
endmodule : alu_unit

// ### core/arith_if.sv
`timescale 1ns/1ps
interface arith_if;
  import alu_mac_pkg::*;
  logic [DATA_W-1:0] x;
  logic [DATA_W-1:0] y;
  alu_op_t alu_op;
  logic carry_in;
  logic [DATA_W-1:0] alu_res;
  logic alu_ovf;
  logic alu_carry;
  mac_op_t mac_op;
  logic x_signed;
  logic y_signed;
  logic int_mode;
  logic round;
  logic biased;
  logic [ACC_W-1:0] acc_in;
  logic [ACC_W-1:0] acc_out;
  logic round_tie;
  logic pre_bit16;
  modport ctrl (output x, y, alu_op, carry_in, mac_op, x_signed, y_signed, int_mode, round, biased, acc_in,
    input alu_res, alu_ovf, alu_carry, acc_out, round_tie, pre_bit16);
  modport alu_side (input x, y, alu_op, carry_in, output alu_res, alu_ovf, alu_carry);
  modport mac_side (input x, y, mac_op, x_signed, y_signed, int_mode, round, biased, acc_in,
    output acc_out, round_tie, pre_bit16);
endinterface : arith_if

// ### core/mac_unit.sv
`timescale 1ns/1ps
module mac_unit (
  arith_if.mac_side io
);
  import alu_mac_pkg::*;
  logic signed [DATA_W:0] xs;
  logic signed [DATA_W:0] ys;
  logic signed [2*DATA_W+1:0] prod;
  logic [ACC_W-1:0] aligned;
  logic [ACC_W-1:0] base;
  logic [ACC_W-1:0] sum;
  logic [ACC_W-1:0] rounded;

  always_comb begin
    xs = {io.x_signed & io.x[DATA_W-1], io.x};
    ys = {io.y_signed & io.y[DATA_W-1], io.y};
    prod = xs * ys;
    // Product taken as signed 32 bits and sign-extended over the accumulator
    if (io.int_mode) begin
      aligned = {{(ACC_W-2*DATA_W){prod[2*DATA_W-1]}}, prod[2*DATA_W-1:0]}; // RQ3
    end else begin
      aligned = {{(ACC_W-2*DATA_W-1){prod[2*DATA_W-1]}}, prod[2*DATA_W-1:0], 1'b0}; // RQ1 RQ2
    end
    base = (io.mac_op == MAC_MUL) ? '0 : io.acc_in;
    sum = (io.mac_op == MAC_SUB) ? base - aligned : base + aligned; // RQ5
    io.round_tie = (sum[DATA_W-1:0] == RND_HALF);
    io.pre_bit16 = sum[RND_FORCE_BIT];
    rounded = sum + RND_ONE; // RQ16
    if (!io.biased && io.round_tie) begin
      rounded[RND_FORCE_BIT] = 1'b0; // RQ17
    end
    // Low word after rounding is left as the adder gives it; not meaningful
    io.acc_out = io.round ? rounded : sum; // RQ18 RQ19
  end
endmodule : mac_unit

// ### verification/alu_mac_mode_control_tb_top.sv
`timescale 1ns/1ps
module alu_mac_mode_control_tb_top;
  import alu_mac_pkg::*;
  logic aclk;
  logic aresetn;
  logic awvalid;
  logic awready;
  logic [ADDR_W-1:0] awaddr;
  logic wvalid;
  logic wready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic bvalid;
  logic bready;
  logic [1:0] bresp;
  logic arvalid;
  logic arready;
  logic [ADDR_W-1:0] araddr;
  logic rvalid;
  logic rready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic [1:0] last_resp;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;

  alu_mac_mode_control i_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .awprot(3'h0),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .arprot(3'h0),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard: the whole sequence needs well under a thousand transfers
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      $display("MISMATCH watchdog expected finish seen hang");
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_resp(input string what, input logic [1:0] exp);
    comparisons++;
    if (last_resp !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, last_resp);
    end
  endtask : chk_resp

  // Ready is judged at the settled negedge, release happens on the taking edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic aw_hit;
    logic w_hit;
    logic aw_done;
    logic w_done;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(negedge aclk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      @(posedge aclk);
      if (aw_hit) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_hit) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    last_resp = bresp;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    last_resp = rresp;
    @(posedge aclk);
  endtask : rd

  task automatic rchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(what, exp, v);
  endtask : rchk

  task automatic mac(input logic [31:0] ops, input logic [31:0] cmd);
    wr(OPERAND_OFS, ops);
    wr(MAC_CMD_OFS, cmd);
  endtask : mac

  task automatic t_bus();
    rchk("mode reset", MODE_OFS, 32'h0);
    rchk("intctl reset", INTCTL_OFS, 32'h0);
    rchk("status reset", STATUS_OFS, 32'h0);
    rchk("unmapped read", 8'h38, 32'h0);
    chk_resp("unmapped rresp", RESP_SLVERR);
    wr(8'h3c, 32'hffff_ffff);
    chk_resp("unmapped bresp", RESP_SLVERR);
    wr(ALU_RES_OFS, 32'h0000_1234);
    chk_resp("ro bresp", RESP_OKAY);
    rchk("ro unchanged", ALU_RES_OFS, 32'h0);
    wr(OPERAND_OFS, 32'h0005_0003);
    wr(OPERAND_OFS, 32'hffff_0009, 4'h3);
    rchk("operand strobe", OPERAND_OFS, 32'h0005_0009);
    rchk("cmd reads zero", ALU_CMD_OFS, 32'h0);
  endtask : t_bus

  task automatic t_frac();
    wr(MODE_OFS, 32'h0);
    mac(32'h4000_4000, 32'h0c);
    rchk("frac mid", ACC_MID_OFS, 32'h0000_2000);
    rchk("frac lo", ACC_LO_OFS, 32'h0);
    mac(32'h0001_0001, 32'h0c);
    rchk("frac lsb", ACC_LO_OFS, 32'h2);
    mac(32'h8000_8000, 32'h0c);
    rchk("frac b31 mid", ACC_MID_OFS, 32'h0000_8000);
    rchk("frac b31 up", ACC_UP_OFS, 32'h0);
    mac(32'h4000_8000, 32'h0c);
    rchk("frac neg mid", ACC_MID_OFS, 32'h0000_c000);
    rchk("frac neg up", ACC_UP_OFS, 32'hffff_ffff);
  endtask : t_frac

  task automatic t_int();
    wr(MODE_OFS, 32'h10);
    mac(32'h7fff_7fff, 32'h0c);
    rchk("int lo", ACC_LO_OFS, 32'h1);
    rchk("int mid", ACC_MID_OFS, 32'h3fff);
    rchk("int up", ACC_UP_OFS, 32'h0);
    for (int i = 0; i < 4; i++) begin
      mac(32'h7fff_7fff, 32'h0d);
    end
    rchk("acc lo", ACC_LO_OFS, 32'h5);
    rchk("acc up", ACC_UP_OFS, 32'h1);
    mac(32'h0001_0005, 32'h0e);
    rchk("sub lo", ACC_LO_OFS, 32'h0);
    rchk("sub mid", ACC_MID_OFS, 32'h3ffb);
  endtask : t_int

  // Low word is not checked after rounding: its content is undefined
  task automatic rnd(input logic [31:0] bias, input logic [31:0] ops, input logic [31:0] cmd,
      input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    wr(INTCTL_OFS, bias);
    mac(ops, cmd);
    rchk("rounded mid", a, exp);
  endtask : rnd

  task automatic t_round();
    wr(MODE_OFS, 32'h10);
    rnd(32'h00, 32'h0001_8000, 32'h10, ACC_MID_OFS, 32'h0);
    rnd(32'h80, 32'h0001_8000, 32'h10, ACC_MID_OFS, 32'h1);
    rnd(32'h00, 32'h0003_8000, 32'h10, ACC_MID_OFS, 32'h2);
    rnd(32'h00, 32'h0001_8001, 32'h10, ACC_MID_OFS, 32'h1);
    rnd(32'h80, 32'h0001_8001, 32'h10, ACC_MID_OFS, 32'h1);
    rnd(32'h80, 32'h0001_7fff, 32'h10, ACC_MID_OFS, 32'h0);
    rnd(32'h00, 32'h0001_8000, 32'h30, SHF_MID_OFS, 32'h0);
    rnd(32'h80, 32'h0001_8000, 32'h30, SHF_MID_OFS, 32'h1);
    mac(32'h0001_0003, 32'h20);
    mac(32'h0001_0003, 32'h21);
    rchk("shifter accumulate", SHF_LO_OFS, 32'h6);
  endtask : t_round

  task automatic alu(input logic [31:0] ops, input logic [31:0] cmd, input logic [ADDR_W-1:0] a,
      input logic [31:0] er, input logic [31:0] es);
    wr(OPERAND_OFS, ops);
    wr(ALU_CMD_OFS, cmd);
    rchk("alu out", a, er);
    rchk("alu status", STATUS_OFS, es);
  endtask : alu

  task automatic t_alu();
    wr(MODE_OFS, 32'h08);
    alu(32'h0001_7fff, 32'h0, ALU_RES_OFS, 32'h7fff, 32'h1);
    alu(32'h0001_8000, 32'h1, ALU_RES_OFS, 32'h8000, 32'h3);
    alu(32'h0001_ffff, 32'h0, ALU_RES_OFS, 32'h0000, 32'h2);
    alu(32'h0001_7fff, 32'h8, ALU_FB_OFS, 32'h8000, 32'h1);
    rchk("result kept", ALU_RES_OFS, 32'h0);
    wr(MODE_OFS, 32'h04);
    alu(32'h0001_7fff, 32'h0, ALU_RES_OFS, 32'h8000, 32'h1);
    alu(32'h0001_0001, 32'h0, ALU_RES_OFS, 32'h0002, 32'h1);
    wr(STATUS_OFS, 32'h0);
    rchk("status cleared", STATUS_OFS, 32'h0);
    wr(MODE_OFS, 32'h0);
    alu(32'h7fff_8000, 32'h1, ALU_RES_OFS, 32'h0001, 32'h3);
    alu(32'h0001_0001, 32'h0, ALU_RES_OFS, 32'h0002, 32'h0);
    alu(32'h0001_ffff, 32'h0, ALU_RES_OFS, 32'h0000, 32'h2);
    alu(32'h0001_0001, 32'h2, ALU_RES_OFS, 32'h0003, 32'h0);
    alu(32'h00f0_ffff, 32'h3, ALU_RES_OFS, 32'h00f0, 32'h0);
    alu(32'h0000_1234, 32'h4, ALU_RES_OFS, 32'h1234, 32'h0);
  endtask : t_alu

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    awaddr = '0;
    wvalid = 1'b0;
    wdata = '0;
    wstrb = 4'hf;
    bready = 1'b1;
    arvalid = 1'b0;
    araddr = '0;
    rready = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_bus();
    t_frac();
    t_int();
    t_round();
    t_alu();
    wrap_up();
  end
endmodule : alu_mac_mode_control_tb_top
